//--- inc/rxrb_pkg.sv
// shared constants for the receive ring bookkeeping block
package rxrb_pkg;

  // ring address and register widths
  localparam int AW   = 13;
  localparam int HI_W = AW - 8;

  typedef logic [AW-1:0] rxrb_addr_t;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_IRQ_EN  = 8'h00;
  localparam logic [7:0] OFF_IRQ_FLG = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_CTRL2   = 8'h0c;
  localparam logic [7:0] OFF_CTRL1   = 8'h10;
  localparam logic [7:0] OFF_START_L = 8'h14;
  localparam logic [7:0] OFF_START_H = 8'h18;
  localparam logic [7:0] OFF_END_L   = 8'h1c;
  localparam logic [7:0] OFF_END_H   = 8'h20;
  localparam logic [7:0] OFF_RDPT_L  = 8'h24;
  localparam logic [7:0] OFF_RDPT_H  = 8'h28;
  localparam logic [7:0] OFF_WRPT_L  = 8'h2c;
  localparam logic [7:0] OFF_WRPT_H  = 8'h30;
  localparam logic [7:0] OFF_PKTCNT  = 8'h34;
  localparam logic [7:0] OFF_MAXFL_L = 8'h38;
  localparam logic [7:0] OFF_MAXFL_H = 8'h3c;

  // bit positions
  localparam int BIT_PKT   = 6;  // irq flags / enable: packet pending
  localparam int BIT_RXERR = 0;  // irq flags / enable: receive error
  localparam int BIT_BUSY  = 2;  // status: frame in progress
  localparam int BIT_DEC   = 6;  // ctrl2: packet count decrement
  localparam int BIT_RX_ENABLE_BIT  = 2;  // ctrl1: reception enable

  // counts and reset values
  localparam logic [7:0]  CNT_MAX   = 8'hff;
  localparam logic [7:0]  CNT_ONE   = 8'h01;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_MAXFL = 16'h05ee;
  localparam logic [15:0] LEN_ONE   = 16'h0001;
  localparam rxrb_addr_t  RST_ADDR  = 13'h0000;
  localparam rxrb_addr_t  RST_END   = 13'h1fff;
  localparam rxrb_addr_t  ADDR_ONE  = 13'h0001;

  // next ring position: wraps from the end address back to start
  function automatic rxrb_addr_t rxrb_wrap(input rxrb_addr_t pos,
                                           input rxrb_addr_t st,
                                           input rxrb_addr_t nd);
    rxrb_wrap = (pos == nd) ? st : pos + ADDR_ONE;
  endfunction

endpackage

//--- inc/rxrb_ptr_if.sv
`timescale 1ns/10ps
// links the register side to the ring write walker
interface rxrb_ptr_if;
  rxrb_pkg::rxrb_addr_t start_addr;  // ring start
  rxrb_pkg::rxrb_addr_t end_addr;    // ring end
  rxrb_pkg::rxrb_addr_t rdpt;        // software read boundary
  rxrb_pkg::rxrb_addr_t wrpt;        // committed write pointer
  logic [15:0]          maxfl;       // maximum frame length
  logic                 rx_en;       // reception enabled
  logic                 cnt_full;    // pending count at its ceiling
  logic                 in_valid;    // received byte strobe
  logic [7:0]           in_data;     // received byte
  logic                 in_last;     // last byte of frame
  logic                 in_good;     // frame passed mac checks
  logic                 commit;      // frame accepted pulse
  logic                 abort;       // frame dropped on overflow
  logic                 busy;        // frame in progress
  logic                 buf_we;      // ring memory write
  rxrb_pkg::rxrb_addr_t buf_addr;    // ring memory address
  logic [7:0]           buf_data;    // ring memory data

  // register side
  modport core (output start_addr, end_addr, rdpt, maxfl, rx_en,
                cnt_full, in_valid, in_data, in_last, in_good,
                input wrpt, commit, abort, busy, buf_we, buf_addr,
                buf_data);
  // walker side
  modport walker (input start_addr, end_addr, rdpt, maxfl, rx_en,
                  cnt_full, in_valid, in_data, in_last, in_good,
                  output wrpt, commit, abort, busy, buf_we, buf_addr,
                  buf_data);
endinterface

//--- design/rxrb_walker.sv
`timescale 1ns/10ps
// walks received bytes through the ring and commits whole frames
module rxrb_walker (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link to register side
  rxrb_ptr_if.walker     ifc
);

  typedef enum logic [1:0] {RW_IDLE, RW_RECV, RW_DROP} rxrb_walk_e;

  rxrb_walk_e           state;  // frame progress
  rxrb_pkg::rxrb_addr_t pos;    // next byte address in frame
  rxrb_pkg::rxrb_addr_t base;   // address for this byte
  logic [15:0]          len;    // bytes stored so far
  logic                 lost;   // frame overflowed space or length
  logic                 fit;    // this byte may be stored
  logic                 ok;     // this byte is stored

  // a new frame starts at the committed pointer
  assign base = (state == RW_IDLE) ? ifc.wrpt : pos;
  // stop one byte short of the read boundary
  assign fit  = (rxrb_pkg::rxrb_wrap(base, ifc.start_addr, ifc.end_addr)
                 != ifc.rdpt) && (len < ifc.maxfl);
  assign ok   = ifc.rx_en && (state != RW_DROP) && fit;
  assign ifc.busy = (state != RW_IDLE);

  // frame state, position and length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RW_IDLE;
      pos   <= rxrb_pkg::RST_ADDR;
      len   <= '0;
      lost  <= 1'b0;
    end else if (ifc.in_valid && (ifc.rx_en || state != RW_IDLE)) begin
      if (ok) begin
        pos <= rxrb_pkg::rxrb_wrap(base, ifc.start_addr, ifc.end_addr);
        len <= len + rxrb_pkg::LEN_ONE;
      end
      if (ifc.in_last) begin
        state <= RW_IDLE;
        len   <= '0;
        lost  <= 1'b0;
      end else begin
        state <= ok ? RW_RECV : RW_DROP;
        lost  <= lost | (ifc.rx_en & ~fit);
      end
    end
  end

  // ring memory write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc.buf_we   <= 1'b0;
      ifc.buf_addr <= rxrb_pkg::RST_ADDR;
      ifc.buf_data <= rxrb_pkg::RST_BYTE;
    end else begin
      ifc.buf_we <= ifc.in_valid && ok;
      if (ifc.in_valid && ok) begin
        ifc.buf_addr <= base;
        ifc.buf_data <= ifc.in_data;
      end
    end
  end

  // commit only a good, complete frame; overflow drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc.wrpt   <= rxrb_pkg::RST_ADDR;
      ifc.commit <= 1'b0;
      ifc.abort  <= 1'b0;
    end else begin
      ifc.commit <= 1'b0;
      ifc.abort  <= 1'b0;
      if (ifc.in_valid && ifc.in_last && state != RW_IDLE | ifc.rx_en
          && ifc.in_valid && ifc.in_last) begin
        if (ok && ifc.in_good && !lost && !ifc.cnt_full) begin
          ifc.commit <= 1'b1;
          ifc.wrpt   <= rxrb_pkg::rxrb_wrap(base, ifc.start_addr,
                                            ifc.end_addr);
        end else if (lost || ifc.cnt_full || (ifc.rx_en && !fit)) begin
          ifc.abort <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrpt_commit_only: assert property (
    $changed(ifc.wrpt) |-> ifc.commit && $past(ifc.in_valid && ifc.in_last))
    else $error("write pointer moved without a frame commit");
  a_guard_boundary: assert property (
    ifc.commit |-> ifc.wrpt != $past(ifc.rdpt))
    else $error("write pointer landed on read boundary");
  a_ring_wraps: assert property (
    ifc.in_valid && ok && base == ifc.end_addr && !ifc.in_last
    |=> pos == $past(ifc.start_addr))
    else $error("ring position did not wrap to start");

endmodule // rxrb_walker

//--- design/rxrb_top.sv
`timescale 1ns/10ps
// Overview of operation
// - write pointer moves only on good frames
// - pointer bytes read live, no latching
// - write pointer never lands on boundary
// - start and end are split 13-bit
// - maximum frame length is split 16-bit
// - boundary low byte held until high write
// - decrement lowers count, pending clears at zero
// - full count aborts frames, flags error
module rxrb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive byte stream from the mac
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_good,
  // ring memory write port
  output logic             buf_we,
  output logic [12:0]      buf_addr,
  output logic [7:0]       buf_data,
  // interrupt
  output logic             irq
);

  rxrb_ptr_if ifc ();

  logic [7:0]           irq_en;      // interrupt mask
  logic [7:0]           irq_flags;   // sticky event flags
  logic                 rx_enable;   // reception enable bit
  rxrb_pkg::rxrb_addr_t rx_start;    // ring start address
  rxrb_pkg::rxrb_addr_t rx_end;      // ring end address
  rxrb_pkg::rxrb_addr_t rdpt;        // read boundary pointer
  logic [7:0]           rdpt_hold;   // buffered boundary low byte
  logic [15:0]          maxfl;       // maximum frame length
  logic [7:0]           pkt_cnt;     // pending packet count
  logic                 wr_acc;      // write access phase
  logic                 rd_setup;    // read setup phase
  logic                 hit;         // address is mapped
  logic                 dec_req;     // decrement strobe
  logic                 dec_ok;      // decrement that takes effect
  logic                 flag_clr;    // write-one-to-clear access
  logic [31:0]          next_rdata;  // read mux

  // apb phases
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign flag_clr = wr_acc && paddr == rxrb_pkg::OFF_IRQ_FLG;
  assign dec_req  = wr_acc && paddr == rxrb_pkg::OFF_CTRL2
                    && pwdata[rxrb_pkg::BIT_DEC];
  assign dec_ok   = dec_req && pkt_cnt != 8'h00;

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // hand the block state to the walker
  assign ifc.start_addr = rx_start;
  assign ifc.end_addr   = rx_end;
  assign ifc.rdpt       = rdpt;
  assign ifc.maxfl      = maxfl;
  assign ifc.rx_en      = rx_enable;
  // a commit in flight at 254 already takes the last slot
  assign ifc.cnt_full   = (pkt_cnt == rxrb_pkg::CNT_MAX) ||
                          (ifc.commit && !dec_ok &&
                           pkt_cnt == rxrb_pkg::CNT_MAX - rxrb_pkg::CNT_ONE);
  assign ifc.in_valid   = rx_valid;
  assign ifc.in_data    = rx_data;
  assign ifc.in_last    = rx_last;
  assign ifc.in_good    = rx_good;
  assign buf_we         = ifc.buf_we;
  assign buf_addr       = ifc.buf_addr;
  assign buf_data       = ifc.buf_data;

  rxrb_walker u_walker (
    .pclk    (pclk),
    .presetn (presetn),
    .ifc     (ifc.walker)
  );

  // address decode and read mux
  always_comb begin
    hit        = 1'b1;
    next_rdata = '0;
    case (paddr)
      rxrb_pkg::OFF_IRQ_EN:  next_rdata[7:0] = irq_en;
      rxrb_pkg::OFF_IRQ_FLG: next_rdata[7:0] = irq_flags;
      rxrb_pkg::OFF_STATUS:  next_rdata[rxrb_pkg::BIT_BUSY] = ifc.busy;
      rxrb_pkg::OFF_CTRL2:   next_rdata = '0;  // decrement reads zero
      rxrb_pkg::OFF_CTRL1:   next_rdata[rxrb_pkg::BIT_RX_ENABLE_BIT] = rx_enable;
      rxrb_pkg::OFF_START_L: next_rdata[7:0] = rx_start[7:0];
      rxrb_pkg::OFF_START_H: next_rdata[4:0] = rx_start[12:8];
      rxrb_pkg::OFF_END_L:   next_rdata[7:0] = rx_end[7:0];
      rxrb_pkg::OFF_END_H:   next_rdata[4:0] = rx_end[12:8];
      // actual pointer, never the held low byte
      rxrb_pkg::OFF_RDPT_L:  next_rdata[7:0] = rdpt[7:0];
      rxrb_pkg::OFF_RDPT_H:  next_rdata[4:0] = rdpt[12:8];
      // live pointer bytes, no pairing latch
      rxrb_pkg::OFF_WRPT_L:  next_rdata[7:0] = ifc.wrpt[7:0];
      rxrb_pkg::OFF_WRPT_H:  next_rdata[4:0] = ifc.wrpt[12:8];
      rxrb_pkg::OFF_PKTCNT:  next_rdata[7:0] = pkt_cnt;
      rxrb_pkg::OFF_MAXFL_L: next_rdata[7:0] = maxfl[7:0];
      rxrb_pkg::OFF_MAXFL_H: next_rdata[7:0] = maxfl[15:8];
      default:               hit = 1'b0;  // unmapped reads zero
    endcase
  end

  // read data register, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en    <= rxrb_pkg::RST_BYTE;
      rx_enable <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == rxrb_pkg::OFF_IRQ_EN) begin
        irq_en <= pwdata[7:0];
      end
      if (paddr == rxrb_pkg::OFF_CTRL1) begin
        rx_enable <= pwdata[rxrb_pkg::BIT_RX_ENABLE_BIT];
      end
    end
  end

  // ring bounds, each split into low and high bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_start <= rxrb_pkg::RST_ADDR;
      rx_end   <= rxrb_pkg::RST_END;
    end else if (wr_acc) begin
      case (paddr)
        rxrb_pkg::OFF_START_L: rx_start[7:0]  <= pwdata[7:0];
        rxrb_pkg::OFF_START_H: rx_start[12:8] <= pwdata[4:0];
        rxrb_pkg::OFF_END_L:   rx_end[7:0]    <= pwdata[7:0];
        rxrb_pkg::OFF_END_H:   rx_end[12:8]   <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // maximum frame length, low and high bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maxfl <= rxrb_pkg::RST_MAXFL;
    end else if (wr_acc && paddr == rxrb_pkg::OFF_MAXFL_L) begin
      maxfl[7:0] <= pwdata[7:0];
    end else if (wr_acc && paddr == rxrb_pkg::OFF_MAXFL_H) begin
      maxfl[15:8] <= pwdata[7:0];
    end
  end

  // read boundary: low byte waits in a hidden holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdpt      <= rxrb_pkg::RST_ADDR;
      rdpt_hold <= rxrb_pkg::RST_BYTE;
    end else if (wr_acc && paddr == rxrb_pkg::OFF_RDPT_L) begin
      rdpt_hold <= pwdata[7:0];
    end else if (wr_acc && paddr == rxrb_pkg::OFF_RDPT_H) begin
      rdpt <= {pwdata[4:0], rdpt_hold};
    end
  end

  // pending packet count: commit adds, decrement removes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_cnt <= rxrb_pkg::RST_BYTE;
    end else if (ifc.commit && !dec_ok) begin
      pkt_cnt <= pkt_cnt + rxrb_pkg::CNT_ONE;
    end else if (dec_ok && !ifc.commit) begin
      pkt_cnt <= pkt_cnt - rxrb_pkg::CNT_ONE;
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags <= rxrb_pkg::RST_BYTE;
    end else begin
      if (ifc.commit) begin
        irq_flags[rxrb_pkg::BIT_PKT] <= 1'b1;
      end else if ((dec_ok && pkt_cnt == rxrb_pkg::CNT_ONE) ||
                   (flag_clr && pwdata[rxrb_pkg::BIT_PKT])) begin
        irq_flags[rxrb_pkg::BIT_PKT] <= 1'b0;
      end
      if (ifc.abort) begin
        irq_flags[rxrb_pkg::BIT_RXERR] <= 1'b1;
      end else if (flag_clr && pwdata[rxrb_pkg::BIT_RXERR]) begin
        irq_flags[rxrb_pkg::BIT_RXERR] <= 1'b0;
      end
    end
  end

  // level interrupt from unmasked flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flags & irq_en);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pointer bytes are read live, no pairing latch
  a_wrpt_live_read: assert property (
    rd_setup && paddr == rxrb_pkg::OFF_WRPT_H
    |=> prdata[4:0] == $past(ifc.wrpt[12:8]) && prdata[31:5] == '0)
    else $error("write pointer high byte not read live");

  a_wrpt_low_live: assert property (
    rd_setup && paddr == rxrb_pkg::OFF_WRPT_L
    |=> prdata[7:0] == $past(ifc.wrpt[7:0]) && prdata[31:8] == '0)
    else $error("write pointer low byte not read live");

  // split registers keep the untouched half
  a_start_split: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_START_H
    |=> rx_start == {$past(pwdata[4:0]), $past(rx_start[7:0])})
    else $error("start high byte write wrong");

  a_end_split: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_END_H
    |=> rx_end == {$past(pwdata[4:0]), $past(rx_end[7:0])})
    else $error("end high byte write wrong");

  a_maxfl_split: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_MAXFL_L
    |=> maxfl == {$past(maxfl[15:8]), $past(pwdata[7:0])})
    else $error("frame length low byte write wrong");

  a_maxfl_high: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_MAXFL_H
    |=> maxfl == {$past(pwdata[7:0]), $past(maxfl[7:0])})
    else $error("frame length high byte write wrong");

  // boundary moves only with its high byte
  a_rdpt_low_held: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_RDPT_L |=> $stable(rdpt))
    else $error("boundary moved on low byte write");

  a_rdpt_pair_load: assert property (
    wr_acc && paddr == rxrb_pkg::OFF_RDPT_H
    |=> rdpt == {$past(pwdata[4:0]), $past(rdpt_hold)})
    else $error("boundary pair not loaded together");

  a_rdpt_read_actual: assert property (
    rd_setup && paddr == rxrb_pkg::OFF_RDPT_L
    |=> prdata[7:0] == $past(rdpt[7:0]))
    else $error("boundary low read not the actual pointer");

  // pending count follows commits and decrements
  a_count_decrement: assert property (
    dec_req && !ifc.commit && pkt_cnt != 8'h00
    |=> pkt_cnt == $past(pkt_cnt) - rxrb_pkg::CNT_ONE)
    else $error("decrement did not lower count by one");

  a_pending_clears: assert property (
    dec_req && !ifc.commit && pkt_cnt == rxrb_pkg::CNT_ONE
    |=> pkt_cnt == 8'h00 && !irq_flags[rxrb_pkg::BIT_PKT])
    else $error("pending flag not cleared at zero");

  a_commit_counts: assert property (
    ifc.commit && !dec_req
    |=> pkt_cnt == $past(pkt_cnt) + rxrb_pkg::CNT_ONE)
    else $error("commit did not raise count by one");

  a_count_floor: assert property (
    dec_req && !ifc.commit && pkt_cnt == rxrb_pkg::RST_BYTE
    |=> pkt_cnt == rxrb_pkg::RST_BYTE)
    else $error("count decremented below zero");

  // ceiling refuses frames and flags an error
  a_full_aborts: assert property (
    pkt_cnt == rxrb_pkg::CNT_MAX && !dec_req |=> !ifc.commit)
    else $error("frame accepted with full count");

  a_count_no_wrap: assert property (
    pkt_cnt == rxrb_pkg::CNT_MAX && !dec_req
    |=> pkt_cnt == rxrb_pkg::CNT_MAX)
    else $error("count left its ceiling without a decrement");

  a_abort_flags: assert property (
    ifc.abort |=> irq_flags[rxrb_pkg::BIT_RXERR]
    ##1 (irq || !$past(irq_en[rxrb_pkg::BIT_RXERR])))
    else $error("abort did not raise receive error");

endmodule // rxrb_top

//--- tb/tb_rxrb_top.sv
`timescale 1ns/10ps
// register and receive-stream bench for the receive ring bookkeeping block
module tb_rxrb_top;
  logic        pclk;      // apb clock
  logic        presetn;   // async reset, active low
  logic [7:0]  paddr;     // apb address
  logic        psel;      // apb select
  logic        penable;   // apb enable
  logic        pwrite;    // apb direction
  logic [31:0] pwdata;    // apb write data
  logic [31:0] prdata;    // apb read data
  logic        pready;    // apb ready
  logic        pslverr;   // apb error
  logic        rx_valid;  // byte strobe
  logic [7:0]  rx_data;   // received byte
  logic        rx_last;   // last byte of frame
  logic        rx_good;   // frame passed mac checks
  logic        buf_we;    // ring write strobe
  logic [12:0] buf_addr;  // ring write address
  logic [7:0]  buf_data;  // ring write data
  logic        irq;       // interrupt level
  int          err_count; // mismatches
  int          n_checks;  // comparisons
  logic [31:0] rd;        // data of the last read
  logic        slv;       // error of the last access
  logic [12:0] pos;       // expected next ring address
  logic [12:0] rend;      // ring end as programmed
  logic [12:0] w;         // write pointer as read
  int          fs;        // free space or lag in bytes

  // block under test
  rxrb_top dut (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rx_valid(rx_valid),
    .rx_data (rx_data),
    .rx_last (rx_last),
    .rx_good (rx_good),
    .buf_we  (buf_we),
    .buf_addr(buf_addr),
    .buf_data(buf_data),
    .irq     (irq)
  );

  // free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // compare and count
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // free bytes in the ring, worked out the way software does it
  function automatic int free_space(input logic [12:0] wp,
                                    input logic [12:0] rp,
                                    input logic [12:0] st,
                                    input logic [12:0] nd);
    if (wp > rp) begin
      return (nd - st) - (wp - rp);
    end else if (wp == rp) begin
      return nd - st;
    end
    return rp - wp - 13'h0001;
  endfunction

  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      err_count++;
      end_of_test();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // register read and compare
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, {24'h0, exp});
  endtask

  // write pointer read as a matching byte pair
  task automatic get_wrpt;
    logic [31:0] c0;
    apb(1'b0, rxrb_pkg::OFF_PKTCNT, 32'h0);
    c0 = rd;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, rxrb_pkg::OFF_WRPT_L, 32'h0);
      w[7:0] = rd[7:0];
      apb(1'b0, rxrb_pkg::OFF_WRPT_H, 32'h0);
      w[12:8] = rd[4:0];
      apb(1'b0, rxrb_pkg::OFF_PKTCNT, 32'h0);
      if (rd === c0) begin
        break;
      end
      c0 = rd;
    end
  endtask

  // one received byte, strobe held for one cycle
  task automatic rx_byte(input logic last, input logic good,
                         input logic [7:0] d);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_last <= last;
    rx_good <= good;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    #1;
  endtask

  // whole frame; optionally follow the ring addresses
  task automatic frame(input int n, input logic good, input logic track);
    for (int k = 0; k < n; k++) begin
      rx_byte(k == n - 1, good, 8'(k + 8'ha0));
      if (track) begin
        chk("ring strobe", {31'h0, buf_we}, 32'h1);
        chk("ring address", {19'h0, buf_addr}, {19'h0, pos});
        chk("ring data", {24'h0, buf_data}, {24'h0, 8'(k + 8'ha0)});
        pos = (pos == rend) ? 13'h0000 : pos + 13'h0001;
      end
    end
    repeat (2) @(posedge pclk);
  endtask

  // reset held three cycles
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // hang guard
  initial begin
    #900000;
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    {pclk, psel, penable, pwrite, rx_valid, rx_last, rx_good} = '0;
    {paddr, pwdata, rx_data, err_count, n_checks} = '0;
    presetn = 1'b0;
    do_reset();
    // reset values, field widths, unmapped place
    rdc("end low", rxrb_pkg::OFF_END_L, 8'hff);
    rdc("end high", rxrb_pkg::OFF_END_H, 8'h1f);
    wr(rxrb_pkg::OFF_START_H, 32'hff);
    rdc("start high", rxrb_pkg::OFF_START_H, 8'h1f);
    wr(rxrb_pkg::OFF_START_H, 32'h00);
    rdc("maxlen low", rxrb_pkg::OFF_MAXFL_L, 8'hee);
    rdc("maxlen high", rxrb_pkg::OFF_MAXFL_H, 8'h05);
    wr(rxrb_pkg::OFF_MAXFL_H, 32'h12);
    rdc("maxlen high", rxrb_pkg::OFF_MAXFL_H, 8'h12);
    rdc("maxlen low", rxrb_pkg::OFF_MAXFL_L, 8'hee);
    wr(rxrb_pkg::OFF_MAXFL_H, 32'h05);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, slv}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // boundary low byte waits for the high byte
    wr(rxrb_pkg::OFF_RDPT_L, 32'h0a);
    rdc("boundary held", rxrb_pkg::OFF_RDPT_L, 8'h00);
    wr(rxrb_pkg::OFF_RDPT_H, 32'h00);
    rdc("boundary loaded", rxrb_pkg::OFF_RDPT_L, 8'h0a);
    $display("test registers done");
    // small ring 0..15, boundary at 10
    wr(rxrb_pkg::OFF_END_L, 32'h0f);
    wr(rxrb_pkg::OFF_END_H, 32'h00);
    rend = 13'h000f;
    wr(rxrb_pkg::OFF_IRQ_EN, 32'h41);
    wr(rxrb_pkg::OFF_CTRL1, 32'h04);
    rx_byte(1'b0, 1'b1, 8'h11);
    rx_byte(1'b0, 1'b1, 8'h12);
    get_wrpt();
    chk("pointer mid frame", {19'h0, w}, 32'h0);
    rdc("busy mid frame", rxrb_pkg::OFF_STATUS, 8'h04);
    fs = 32'(buf_addr) + 32'h1 - 32'(w);
    chk("stale", {31'h0, fs <= rxrb_pkg::RST_MAXFL + 16'h0008}, 32'h1);
    rx_byte(1'b1, 1'b1, 8'h13);
    repeat (2) @(posedge pclk);
    get_wrpt();
    chk("pointer after frame", {19'h0, w}, 32'h3);
    chk("irq pending", {31'h0, irq}, 32'h1);
    frame(4, 1'b0, 1'b0);
    get_wrpt();
    chk("pointer bad frame", {19'h0, w}, 32'h3);
    rdc("count bad frame", rxrb_pkg::OFF_PKTCNT, 8'h01);
    // frame that would land on the boundary, then one that just fits
    fs = free_space(w, 13'h000a, 13'h0000, rend);
    frame(fs + 1, 1'b1, 1'b0);
    get_wrpt();
    chk("pointer at boundary", {19'h0, w}, 32'h3);
    rdc("flags boundary", rxrb_pkg::OFF_IRQ_FLG, 8'h41);
    pos = 13'h0003;
    frame(fs, 1'b1, 1'b1);
    get_wrpt();
    chk("pointer fit", {19'h0, w}, 32'h9);
    // error flag clear and masking
    wr(rxrb_pkg::OFF_IRQ_FLG, 32'h01);
    rdc("flags cleared", rxrb_pkg::OFF_IRQ_FLG, 8'h40);
    wr(rxrb_pkg::OFF_IRQ_EN, 32'h00);
    repeat (2) @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(rxrb_pkg::OFF_IRQ_EN, 32'h40);
    $display("test frames and boundary done");
    // wrap from ring end to start
    wr(rxrb_pkg::OFF_RDPT_L, 32'h02);
    wr(rxrb_pkg::OFF_RDPT_H, 32'h00);
    fs = free_space(w, 13'h0002, 13'h0000, rend);
    frame(fs, 1'b1, 1'b1);
    get_wrpt();
    chk("pointer wrapped", {19'h0, w}, 32'h1);
    // decrement down to zero and one step below
    rdc("count three", rxrb_pkg::OFF_PKTCNT, 8'h03);
    wr(rxrb_pkg::OFF_CTRL2, 32'h40);
    wr(rxrb_pkg::OFF_CTRL2, 32'h40);
    rdc("count one", rxrb_pkg::OFF_PKTCNT, 8'h01);
    rdc("pending kept", rxrb_pkg::OFF_IRQ_FLG, 8'h40);
    wr(rxrb_pkg::OFF_CTRL2, 32'h40);
    rdc("pending gone", rxrb_pkg::OFF_IRQ_FLG, 8'h00);
    chk("irq idle", {31'h0, irq}, 32'h0);
    wr(rxrb_pkg::OFF_CTRL2, 32'h40);
    rdc("count floor", rxrb_pkg::OFF_PKTCNT, 8'h00);
    $display("test wrap and decrement done");
    // count ceiling after a reset in mid-run
    do_reset();
    wr(rxrb_pkg::OFF_IRQ_EN, 32'h01);
    wr(rxrb_pkg::OFF_CTRL1, 32'h04);
    // over-long frame is dropped with an error
    wr(rxrb_pkg::OFF_MAXFL_H, 32'h00);
    wr(rxrb_pkg::OFF_MAXFL_L, 32'h02);
    frame(3, 1'b1, 1'b0);
    rdc("flags long", rxrb_pkg::OFF_IRQ_FLG, 8'h01);
    wr(rxrb_pkg::OFF_IRQ_FLG, 32'h01);
    wr(rxrb_pkg::OFF_MAXFL_H, 32'h05);
    wr(rxrb_pkg::OFF_MAXFL_L, 32'hee);
    for (int f = 0; f < 255; f++) begin
      frame(1, 1'b1, 1'b0);
    end
    rdc("count full", rxrb_pkg::OFF_PKTCNT, 8'hff);
    chk("irq before", {31'h0, irq}, 32'h0);
    frame(2, 1'b1, 1'b0);
    get_wrpt();
    chk("pointer full", {19'h0, w}, 32'hff);
    rdc("count held", rxrb_pkg::OFF_PKTCNT, 8'hff);
    rdc("flags full", rxrb_pkg::OFF_IRQ_FLG, 8'h41);
    chk("irq error", {31'h0, irq}, 32'h1);
    $display("test count ceiling done");
    end_of_test();
  end
endmodule // tb_rxrb_top
